// [apdr_pkg.sv]
/*
 * apdr_pkg: constants for the two-channel converter phase-delay and hard-reset back end.
 * Assumes a single 25 MHz system clock; the modulator sample rate is a one-cycle enable.
 */
package apdr_pkg;
    // system clock and modulator sample tick
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned MOD_TICK_DIV = 25;              // 1 MHz modulator sample enable
    localparam int unsigned MOD_DIV_W = 5;
    // decimation ratio codes
    typedef enum logic [1:0] {APDR_OSR32, APDR_OSR64, APDR_OSR128, APDR_OSR256} apdr_osr_e;
    localparam logic [1:0] OSR_RESET = 2'h3;                 // ratio 256 after reset
    localparam logic [7:0] SKEW_RESET = 8'h00;
    localparam logic EXT_REF_RESET = 1'b0;
    localparam logic EXT_CLK_RESET = 1'b0;
    localparam int unsigned WIN_W = 9;                       // counts up to 256
    localparam int unsigned DATA_W = 24;
    localparam logic [3:0] CMP_RESET_PAT = 4'h3;             // comparator pattern 0011
    localparam logic [DATA_W-1:0] DATA_ZERO = 24'h000000;
endpackage

// [apdr_top.sv]
/*
 * apdr_top: skew-controlled decimation windows, data-ready strobes, hard reset and
 * clock/reference source selection of a two-channel delta-sigma back end.
 * Assumes the modulator bitstreams arrive synchronous to clock, one bit per sample tick,
 * and that register writes come from the serial decoder as a strobe with address-decoded enables.
 */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - skew code is signed eight-bit two's complement
// - channel 1 is reference; positive lags channel 0
// - same sampling instants; only channel 0 averaging shifts; the code shifts channel 1 instead for negative codes
// - delay equals code times modulator sample period
// - data-ready strobes offset by the skew
// - skew clamped to minus half to half-minus-one
// - sign bit position follows decimation ratio
// - skew written for 256 rescales automatically; the code only drops the bits above the sign
// - hard reset holds outputs at zero code
// - hard reset clears modulators, comparators 0011
// - hard reset clears filters and output buffers
// - hard reset restores configuration defaults
// - writes ignored while hard reset low
// - outputs released, clocks stopped during hard reset; the code stops only mod_tick, not analog_master_clock
// - strobes start by themselves after reset
// - external clock select bypasses crystal
// - external reference select turns reference pins input
// - strobe pulses per new channel result
module apdr_top (
    input wire logic clock,                       // 25 MHz system clock
    input wire logic reset_n,                     // power-on reset, active low
    input wire logic hard_reset_n,                // hard reset pin, active low
    input wire logic wr_en,                       // register write strobe
    input wire logic wr_skew_sel,                 // write targets channel skew setting
    input wire logic wr_cfg_sel,                  // write targets configuration
    input wire logic [7:0] wr_data,               // write data
    input wire logic crystal_clk_in,              // crystal oscillator clock level
    input wire logic ext_clk_in,                  // externally supplied clock level
    input wire logic mod_bit_ch0,                 // channel 0 modulator bitstream sample
    input wire logic mod_bit_ch1,                 // channel 1 modulator bitstream sample
    output logic [7:0] channel_skew_setting,      // skew register readback
    output logic [1:0] decimation_ratio,          // ratio code readback
    output logic external_ref_select,             // reference pins act as input
    output logic external_clock_select,           // crystal bypassed
    output logic analog_master_clock,             // selected master clock level
    output logic ref_out_en,                      // internal reference drives pins
    output logic [3:0] cmp_force_ch0,             // comparator output forcing, channel 0
    output logic [3:0] cmp_force_ch1,             // comparator output forcing, channel 1
    output logic [apdr_pkg::DATA_W-1:0] data_ch0, // channel 0 result
    output logic [apdr_pkg::DATA_W-1:0] data_ch1, // channel 1 result
    output logic data_ready_strobe_ch0,           // channel 0 new result pulse
    output logic data_ready_strobe_ch1,           // channel 1 new result pulse
    output logic data_ready_oe,                   // strobe pin enable
    output logic modulator_bitstream_out_ch0,     // channel 0 bitstream output
    output logic modulator_bitstream_out_ch1,     // channel 1 bitstream output
    output logic modulator_bitstream_oe           // bitstream pins enable
);
    import apdr_pkg::*;

    logic rst_s1_q, rst_s2_q, rst_n;
    logic hr_q;
    logic [MOD_DIV_W-1:0] div_q;
    logic mod_tick;
    logic [7:0] skew_q;
    logic [1:0] osr_q;
    logic ext_ref_q, ext_clk_q;
    logic [WIN_W-1:0] osr_len, ref_cnt_q, half_len;
    logic signed [WIN_W:0] skew_s, skew_c;
    logic [WIN_W-1:0] skew_mag;
    logic skew_neg;
    logic [WIN_W-1:0] acc0_q, acc1_q;
    logic end0, end1;
    logic [DATA_W-1:0] buf0_q, buf1_q;
    logic dr0_q, dr1_q;
    logic [WIN_W-1:0] off_q;
    logic lag_run_q;

    // reset release synchroniser
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // hard reset state, registered once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) hr_q <= 1'b1;
        else hr_q <= ~hard_reset_n;
    end

    // modulator sample enable, stopped during hard reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (hr_q) begin
            div_q <= '0;
        end else if (div_q == MOD_DIV_W'(MOD_TICK_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign mod_tick = !hr_q && (div_q == MOD_DIV_W'(MOD_TICK_DIV - 1));

    // configuration registers, defaulted by hard reset, writes blocked meanwhile
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            skew_q <= SKEW_RESET;
            osr_q <= OSR_RESET;
            ext_ref_q <= EXT_REF_RESET;
            ext_clk_q <= EXT_CLK_RESET;
        end else if (hr_q) begin
            skew_q <= SKEW_RESET;
            osr_q <= OSR_RESET;
            ext_ref_q <= EXT_REF_RESET;
            ext_clk_q <= EXT_CLK_RESET;
        end else if (wr_en && hard_reset_n) begin
            if (wr_skew_sel) skew_q <= wr_data;
            if (wr_cfg_sel) begin
                osr_q <= wr_data[1:0];
                ext_ref_q <= wr_data[2];
                ext_clk_q <= wr_data[3];
            end
        end
    end

    // source selection
    assign analog_master_clock = ext_clk_q ? ext_clk_in : crystal_clk_in;
    assign ref_out_en = !ext_ref_q;
    assign external_ref_select = ext_ref_q;
    assign external_clock_select = ext_clk_q;
    assign channel_skew_setting = skew_q;
    assign decimation_ratio = osr_q;

    // window length and skew field: the sign moves down to bit 4 plus the ratio code,
    // bit 0 keeps its weight and the bits above the sign are dropped, so a code written at ratio 256 must be rewritten
    always_comb begin
        unique case (apdr_osr_e'(osr_q))
            APDR_OSR32: begin
                osr_len = WIN_W'(32);
                skew_s = (WIN_W+1)'(signed'(skew_q[4:0]));
            end
            APDR_OSR64: begin
                osr_len = WIN_W'(64);
                skew_s = (WIN_W+1)'(signed'(skew_q[5:0]));
            end
            APDR_OSR128: begin
                osr_len = WIN_W'(128);
                skew_s = (WIN_W+1)'(signed'(skew_q[6:0]));
            end
            APDR_OSR256: begin
                osr_len = WIN_W'(256);
                skew_s = (WIN_W+1)'(signed'(skew_q));
            end
        endcase
        half_len = osr_len >> 1;
        // limit to -ratio/2 .. ratio/2-1
        if (skew_s > $signed({1'b0, half_len - 1'b1})) skew_c = $signed({1'b0, half_len - 1'b1});
        else if (skew_s < -$signed({1'b0, half_len})) skew_c = -$signed({1'b0, half_len});
        else skew_c = skew_s;
        skew_neg = skew_c[WIN_W];
        skew_mag = skew_neg ? WIN_W'(-skew_c) : WIN_W'(skew_c);
    end

    // shared window counter: the leading channel ends at its wrap, the lagging channel is offset by skew
    // the counter also wraps early when a ratio change leaves it past the new window
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_q <= '0;
            off_q <= '0;
            lag_run_q <= 1'b0;
        end else if (hr_q) begin
            ref_cnt_q <= '0;
            off_q <= '0;
            lag_run_q <= 1'b0;
        end else if (mod_tick) begin
            ref_cnt_q <= (ref_cnt_q >= osr_len - 1'b1) ? '0 : ref_cnt_q + 1'b1;
            // first lagging window starts skew_mag ticks after the leading one;
            // >= so that a smaller skew written meanwhile cannot stall the start
            if (!lag_run_q) begin
                if (off_q >= skew_mag) begin
                    lag_run_q <= 1'b1;
                end else begin
                    off_q <= off_q + 1'b1;
                end
            end
        end
    end

    // leading channel ends at the counter wrap; lagging one skew_mag ticks later,
    // taken from the live skew so a new setting moves the very next lagging end
    always_comb begin
        logic lead_end, lag_end, lag_hit;
        lead_end = mod_tick && (ref_cnt_q >= osr_len - 1'b1);
        lag_hit = (skew_mag == '0) ? (ref_cnt_q >= osr_len - 1'b1) : (ref_cnt_q == skew_mag - 1'b1);
        lag_end = mod_tick && lag_run_q && lag_hit;
        end1 = skew_neg ? lag_end : lead_end;
        end0 = skew_neg ? lead_end : lag_end;
    end

    // averaging of modulator ones over each window (simplified filter)
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc0_q <= '0;
            acc1_q <= '0;
        end else if (hr_q) begin
            acc0_q <= '0;
            acc1_q <= '0;
        end else if (mod_tick) begin
            acc1_q <= end1 ? '0 : acc1_q + WIN_W'(mod_bit_ch1);
            acc0_q <= end0 ? '0 : acc0_q + WIN_W'(mod_bit_ch0);
        end
    end

    // output buffers and data-ready strobes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buf0_q <= DATA_ZERO;
            buf1_q <= DATA_ZERO;
            dr0_q <= 1'b0;
            dr1_q <= 1'b0;
        end else if (hr_q) begin
            buf0_q <= DATA_ZERO;
            buf1_q <= DATA_ZERO;
            dr0_q <= 1'b0;
            dr1_q <= 1'b0;
        end else begin
            dr0_q <= end0;
            dr1_q <= end1;
            if (end0) buf0_q <= {acc0_q + WIN_W'(mod_bit_ch0), {(DATA_W-WIN_W){1'b0}}};
            if (end1) buf1_q <= {acc1_q + WIN_W'(mod_bit_ch1), {(DATA_W-WIN_W){1'b0}}};
        end
    end

    // pin outputs: strobe and bitstream pins released while hard reset is low, data held at zero, comparators forced
    assign data_ch0 = buf0_q;
    assign data_ch1 = buf1_q;
    assign data_ready_strobe_ch0 = dr0_q;
    assign data_ready_strobe_ch1 = dr1_q;
    assign data_ready_oe = !hr_q;
    assign modulator_bitstream_out_ch0 = hr_q ? 1'b0 : mod_bit_ch0;
    assign modulator_bitstream_out_ch1 = hr_q ? 1'b0 : mod_bit_ch1;
    assign modulator_bitstream_oe = !hr_q;
    assign cmp_force_ch0 = hr_q ? CMP_RESET_PAT : 4'h0;
    assign cmp_force_ch1 = hr_q ? CMP_RESET_PAT : 4'h0;

    // checks
    AST_HR_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
        hr_q |=> (data_ch0 == DATA_ZERO && data_ch1 == DATA_ZERO))
        else $error("data not zero in hard reset");
    AST_HR_CFG: assert property (@(posedge clock) disable iff (!rst_n)
        hr_q |=> (skew_q == SKEW_RESET && osr_q == OSR_RESET))
        else $error("config not defaulted");
    AST_HR_NOWR: assert property (@(posedge clock) disable iff (!rst_n)
        (hr_q && !hard_reset_n) |=> $stable(skew_q) || skew_q == SKEW_RESET)
        else $error("write accepted during hard reset");
    AST_HR_HIZ: assert property (@(posedge clock) disable iff (!rst_n)
        hr_q |-> (!data_ready_oe && !modulator_bitstream_oe && !mod_tick))
        else $error("outputs enabled in hard reset");
    AST_CMP: assert property (@(posedge clock) disable iff (!rst_n)
        hr_q |-> cmp_force_ch0 == 4'h3 && cmp_force_ch1 == 4'h3)
        else $error("comparator pattern wrong");
    AST_CLKSEL: assert property (@(posedge clock) disable iff (!rst_n)
        ext_clk_q |-> analog_master_clock == ext_clk_in)
        else $error("external clock not selected");
    AST_REFSEL: assert property (@(posedge clock) disable iff (!rst_n)
        ext_ref_q |-> !ref_out_en)
        else $error("reference still driven");
    AST_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
        skew_c <= $signed({1'b0, half_len}) - 1 && skew_c >= -$signed({1'b0, half_len}))
        else $error("skew out of range");
    AST_ZERO_SKEW: assert property (@(posedge clock) disable iff (!rst_n || hr_q)
        (skew_mag == '0 && lag_run_q && end1) |-> end0)
        else $error("strobes not aligned at zero skew");

    // strobe shape: every window end gives exactly one cycle of strobe
    sequence seq_pulse0;
        data_ready_strobe_ch0 ##1 !data_ready_strobe_ch0;
    endsequence
    sequence seq_pulse1;
        data_ready_strobe_ch1 ##1 !data_ready_strobe_ch1;
    endsequence
    AST_DR0_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
        end0 |=> seq_pulse0)
        else $error("channel 0 strobe is not a single pulse");
    AST_DR1_PULSE: assert property (@(posedge clock) disable iff (!rst_n)
        end1 |=> seq_pulse1)
        else $error("channel 1 strobe is not a single pulse");
    // windows end only on the shared modulator tick
    AST_TICK_END: assert property (@(posedge clock) disable iff (!rst_n)
        (end0 || end1) |-> mod_tick)
        else $error("window ended off a modulator tick");
    // the lagging window is started once the offset has run out
    AST_LAG_START: assert property (@(posedge clock) disable iff (!rst_n || hr_q)
        (mod_tick && !lag_run_q && off_q >= skew_mag) |=> lag_run_q)
        else $error("lagging window never started");
endmodule
`default_nettype wire

// [apdr_host.sv]
/*
 * apdr_host: behavioural host that owns the hard reset pin and logs data-ready strobes.
 * Assumes strobes and results are synchronous to clock and strobes last one cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module apdr_host (
    input wire logic clock,          // system clock
    input wire logic stb0,           // channel 0 strobe
    input wire logic stb1,           // channel 1 strobe
    input wire logic [23:0] data0,   // channel 0 result
    input wire logic [23:0] data1,   // channel 1 result
    output logic hard_reset_n        // hard reset pin
);
    localparam int SETTLE = 1250;    // 50 us of 40 ns cycles
    int cyc = 0;
    int rel = 0;
    int t0 = 0;
    int t1 = 0;
    int p1 = 0;
    int kept = 0;
    logic [23:0] d0 = 24'h000000;
    logic [23:0] d1 = 24'h000000;
    localparam int COARSE = 2;       // output-word periods of coarse delay
    logic [23:0] fifo0 [$];
    logic [23:0] d0_late = 24'h000000;
    // coarse delay: channel 0 words held back in a host queue
    always @(posedge clock) begin
        if (stb0 && cyc - rel >= SETTLE) begin
            fifo0.push_back(data0);
            if (fifo0.size() > COARSE) d0_late <= fifo0.pop_front();
        end
    end
    // pin low through power-up until the bench lets go
    initial hard_reset_n = 1'b0;
    // log strobes, dropping those inside the bias settling span
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (stb0 && cyc - rel >= SETTLE) begin
            t0 <= cyc;
            d0 <= data0;
        end
        if (stb1 && cyc - rel >= SETTLE) begin
            p1 <= t1;
            t1 <= cyc;
            d1 <= data1;
            kept <= kept + 1;
        end
    end
    // drive the pin just after an edge
    task set_pin(input logic v);
        @(posedge clock);
        hard_reset_n <= v;
        rel <= cyc;
    endtask
endmodule
`default_nettype wire

// [testbench.sv]
/*
 * testbench: self-checking bench for apdr_top with the host model on the far side.
 * Assumes the designer's timing: writes land one cycle after the strobe, one tick per 25 clocks.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import apdr_pkg::*;
    logic clock, reset_n, hard_reset_n, wr_en, wr_skew_sel, wr_cfg_sel;
    logic [7:0] wr_data, channel_skew_setting;
    logic crystal_clk_in, ext_clk_in, mod_bit_ch0, mod_bit_ch1;
    logic [1:0] decimation_ratio;
    logic external_ref_select, external_clock_select, analog_master_clock, ref_out_en;
    logic [3:0] cmp_force_ch0, cmp_force_ch1;
    logic [DATA_W-1:0] data_ch0, data_ch1;
    logic data_ready_strobe_ch0, data_ready_strobe_ch1, data_ready_oe;
    logic modulator_bitstream_out_ch0, modulator_bitstream_out_ch1, modulator_bitstream_oe;
    int mismatches = 0;
    int checked = 0;
    int k0, seed;
    logic [7:0] codes [4] = '{8'h7f, 8'h80, 8'hc0, 8'h10};
    apdr_top apdr_top_i (.*);
    apdr_host apdr_host_i (.clock(clock), .stb0(data_ready_strobe_ch0), .stb1(data_ready_strobe_ch1),
        .data0(data_ch0), .data1(data_ch1), .hard_reset_n(hard_reset_n));
    // free-running 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one-cycle write pulse, then settle past the update
    task wr(input logic s, input logic c, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        wr_skew_sel <= s;
        wr_cfg_sel <= c;
        wr_data <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        @(posedge clock);
        @(negedge clock);
    endtask
    // wait for n channel 1 strobes, bounded
    task automatic wait_stb(input int n);
        int k;
        k = apdr_host_i.kept + n;
        for (int i = 0; i < 60000 && apdr_host_i.kept < k; i++) begin
            @(negedge clock);
        end
        if (apdr_host_i.kept < k) begin
            mismatches++;
        end
    endtask
    // model of the effective skew in tick units for ratio code r: sign at bit 4+r, bit 0 lsb
    function automatic int eff(input logic [7:0] c, input int r);
        int v;
        v = int'(c) & ((32 << r) - 1);
        if (v >= (16 << r)) v = v - (32 << r);
        if (v < -(16 << r)) v = -(16 << r);
        if (v > (16 << r) - 1) v = (16 << r) - 1;
        return v;
    endfunction
    task automatic measure(input logic [7:0] c, input int r, input logic b0);
        int p, e;
        p = (32 << r) * MOD_TICK_DIV;
        e = eff(c, r) * MOD_TICK_DIV;
        @(posedge clock);
        mod_bit_ch0 <= b0;
        mod_bit_ch1 <= ~b0;
        wait_stb(6);
        check(apdr_host_i.t1 - apdr_host_i.p1, p);
        check(((apdr_host_i.t0 - apdr_host_i.t1) % p + p) % p, (e % p + p) % p);
        check(apdr_host_i.d0, b0 ? (32 << r) << 15 : 0);
        check(apdr_host_i.d1, b0 ? 0 : (32 << r) << 15);
        check(apdr_host_i.d0_late, b0 ? (32 << r) << 15 : 0);
        check(modulator_bitstream_out_ch0, b0);
        $display("test skew %h ratio %0d done", c, r);
    endtask
    // watchdog sized well past the longest path
    initial begin
        repeat (90000) @(posedge clock);
        mismatches++;
        summarize();
    end
    initial begin
        {wr_en, wr_skew_sel, wr_cfg_sel, wr_data, mod_bit_ch0, mod_bit_ch1} = '0;
        seed = $urandom(4);
        crystal_clk_in = 1'b0;
        ext_clk_in = 1'b1;
        reset_n = 1'b0;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        apdr_host_i.set_pin(1'b1);
        repeat (4) @(negedge clock);
        check(channel_skew_setting, SKEW_RESET);
        check({decimation_ratio, external_ref_select, external_clock_select}, {OSR_RESET, 2'b00});
        check({ref_out_en, data_ready_oe, cmp_force_ch0}, 6'h30);
        $display("test defaults done");
        wr(1'b0, 1'b1, 8'h0c);
        check({external_ref_select, external_clock_select, ref_out_en}, 3'b110);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            {ext_clk_in, crystal_clk_in} <= 2'(i);
            @(negedge clock);
            check(analog_master_clock, i[1]);
        end
        $display("test clock select done");
        codes[3] = 8'($urandom);
        for (int k = 0; k < 4; k++) begin
            wr(1'b1, 1'b0, codes[k]);
            wr(1'b0, 1'b1, 8'(k % 3));
            check(channel_skew_setting, codes[k]);
            measure(codes[k], k % 3, k[0]);
        end
        apdr_host_i.set_pin(1'b0);
        repeat (2) @(negedge clock);
        wr(1'b1, 1'b1, 8'h55);
        check({channel_skew_setting, decimation_ratio}, {SKEW_RESET, OSR_RESET});
        check({data_ch0, data_ch1}, 48'h0);
        check({cmp_force_ch0, cmp_force_ch1}, {CMP_RESET_PAT, CMP_RESET_PAT});
        check({data_ready_oe, modulator_bitstream_oe, modulator_bitstream_out_ch0}, 3'b000);
        k0 = apdr_host_i.kept;
        apdr_host_i.set_pin(1'b1);
        wait_stb(2);
        check(apdr_host_i.kept - k0, 2);
        check(apdr_host_i.d0, 32'h800000);
        check(apdr_host_i.d1, 32'h0);
        $display("test hard reset done");
        summarize();
    end
endmodule
`default_nettype wire
